// ===== rtl/ieb_pkg.sv
// ieb_pkg: offsets, layouts, reset values and carriers
// for the interrupt enable and receive byte threshold block.
// assumes a 16-bit host data bus with even byte addresses.
package ieb_pkg;

    // ************************************************
    // register offsets
    // ************************************************
    localparam logic [7:0] ADDR_THRESH = 8'h8E;
    localparam logic [7:0] ADDR_ENABLE = 8'h90;
    localparam logic [7:0] ADDR_STATUS = 8'h92;

    // ************************************************
    // reset values and bit masks
    // ************************************************
    localparam logic [15:0] THRESH_RST = 16'h0000;
    localparam logic [15:0] ENABLE_RST = 16'h0000;
    localparam logic [15:0] STATUS_RST = 16'h0300;
    localparam logic [15:0] ENABLE_MASK = 16'hEB7D;
    localparam logic [15:0] STATUS_MASK = 16'hEB7C;
    localparam logic [15:0] W1C_MASK = 16'hEB40;
    localparam logic [15:0] ZERO16 = 16'h0000;

    // ************************************************
    // bit positions
    // ************************************************
    localparam int B_LINK = 15;
    localparam int B_TX = 14;
    localparam int B_RX = 13;
    localparam int B_OVR = 11;
    localparam int B_TXSTOP = 9;
    localparam int B_RXSTOP = 8;
    localparam int B_SPACE = 6;
    localparam int B_WFRAME = 5;
    localparam int B_WPKT = 4;
    localparam int B_LINKUP = 3;
    localparam int B_ENERGY = 2;
    localparam int B_DELAY = 0;

    // ************************************************
    // carriers
    // ************************************************
    typedef struct packed {
        logic link_change;
        logic tx_done;
        logic rx_frame;
        logic rx_overrun;
        logic tx_stopped;
        logic rx_stopped;
        logic tx_space;
    } ieb_event_t;

    typedef struct packed {
        logic wake_frame;
        logic wake_packet;
        logic linkup;
        logic energy;
    } ieb_wake_t;

    typedef struct packed {
        logic cs_b;
        logic rd_b;
        logic wr_b;
        logic [1:0] be_b;
        logic [7:0] addr;
        logic [15:0] wdata;
    } ieb_host_t;

endpackage

// ===== rtl/ieb_irq_ctrl.sv
// ieb_irq_ctrl: interrupt enable, status and receive
// byte threshold trigger behind an asynchronous sram-like
// host port.
// assumes host address, data and byte enables stay stable
// for the whole strobe; event pulses come from core_clk logic.
//
// Notes on behaviour
// - 16-bit byte threshold register, resets zero
// - threshold enable plus bytes crossing above sets receive
// - enable bit 15 gates link change
// - enable bit 14 gates transmit
// - enable bit 13 gates receive incl threshold
// - enable bit 11 gates receive overrun
// - enable bit 9 gates transmit stopped
// - enable bit 8 gates receive stopped
// - enable bit 6 gates transmit space
// - enable bit 5 gates wake frame
// - enable bit 4 gates wake pattern packet
// - enable bit 3 gates linkup wake
// - enable bit 2 gates energy wake while bit 0 is clear
// - bit 0 delays energy until host ready
// - pin asserts on any enabled set status
// - status not cleared by read, write-one clears event bits; wake bits 5-2 follow their inputs
// - receive status at bit 13, frame ready
`timescale 1ns/1ns
module ieb_irq_ctrl
    import ieb_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // host pins
    input wire logic host_cs_b,
    input wire logic host_rd_b,
    input wire logic host_wr_b,
    input wire logic [1:0] host_be_b,
    input wire logic [7:0] host_addr,
    input wire logic [15:0] host_data_in,
    output logic [15:0] host_data_out,
    output logic host_data_oe_b,
    // device event sources
    input wire ieb_event_t evt,
    input wire ieb_wake_t wake,
    input wire logic [15:0] rx_queue_bytes,
    input wire logic rx_byte_thresh_en,
    input wire logic host_ready,
    // interrupt pin
    output logic intr_b
);

    // ************************************************
    // functions
    // ************************************************

    // merge write data into a register by byte lane
    function automatic logic [15:0] lane_merge(
        input logic [15:0] old_val,
        input logic [15:0] new_val,
        input logic [1:0] be_b
    );
        logic [15:0] res;
        res = old_val;
        if (!be_b[0]) begin
            res[7:0] = new_val[7:0];
        end
        if (!be_b[1]) begin
            res[15:8] = new_val[15:8];
        end
        return res;
    endfunction

    // ************************************************
    // reset release and pin synchronisers
    // ************************************************
    logic rst_meta_b, rst_sync_b;
    ieb_host_t host_meta, host_sync, host_pins;

    assign host_pins = '{cs_b: host_cs_b, rd_b: host_rd_b,
                         wr_b: host_wr_b, be_b: host_be_b,
                         addr: host_addr, wdata: host_data_in};

    // two-stage release of the reset
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_b <= 1'b1;
            rst_sync_b <= rst_meta_b;
        end
    end

    // two flops on every host pin
    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            host_meta <= '1;
            host_sync <= '1;
        end else begin
            host_meta <= host_pins;
            host_sync <= host_meta;
        end
    end

    // ************************************************
    // host strobe decode
    // ************************************************
    logic rd_active, wr_active, wr_active_q;
    logic [1:0] wr_be_q;
    logic [7:0] wr_addr_q;
    logic [15:0] wr_data_q;
    logic wr_done;

    assign rd_active = !host_sync.cs_b && !host_sync.rd_b;
    assign wr_active = !host_sync.cs_b && !host_sync.wr_b;
    // write takes effect when the strobe ends
    assign wr_done = wr_active_q && !wr_active;

    // hold the last address and data seen during the strobe
    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            wr_active_q <= 1'b0;
            wr_be_q <= 2'h3;
            wr_addr_q <= 8'h00;
            wr_data_q <= ZERO16;
        end else begin
            wr_active_q <= wr_active;
            if (wr_active) begin
                wr_be_q <= host_sync.be_b;
                wr_addr_q <= host_sync.addr;
                wr_data_q <= host_sync.wdata;
            end
        end
    end

    // ************************************************
    // threshold and enable registers
    // ************************************************
    logic [15:0] rx_byte_threshold_value;
    logic [15:0] interrupt_enable;

    // byte threshold, whole register, bytes
    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            rx_byte_threshold_value <= THRESH_RST;
        end else if (wr_done && wr_addr_q == ADDR_THRESH) begin
            rx_byte_threshold_value <= lane_merge(rx_byte_threshold_value,
                                                  wr_data_q, wr_be_q);
        end
    end

    // enable register, reserved positions held at zero
    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            interrupt_enable <= ENABLE_RST;
        end else if (wr_done && wr_addr_q == ADDR_ENABLE) begin
            interrupt_enable <= lane_merge(interrupt_enable, wr_data_q,
                                           wr_be_q) & ENABLE_MASK;
        end
    end

    // ************************************************
    // byte threshold trigger
    // ************************************************
    logic above_thresh, above_thresh_q, thresh_hit;

    assign above_thresh = rx_queue_bytes > rx_byte_threshold_value;
    // one hit per crossing, so a clear is not undone at once
    assign thresh_hit = rx_byte_thresh_en && above_thresh &&
                        !above_thresh_q;

    // previous compare result
    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            above_thresh_q <= 1'b0;
        end else begin
            above_thresh_q <= above_thresh;
        end
    end

    // ************************************************
    // status register
    // ************************************************
    logic [15:0] interrupt_status;
    logic [15:0] sticky_set;
    logic [15:0] sticky_clr;
    logic [15:0] next_status;

    // edge sources that set sticky bits
    always_comb begin
        sticky_set = ZERO16;
        sticky_set[B_LINK] = evt.link_change;
        sticky_set[B_TX] = evt.tx_done;
        sticky_set[B_RX] = evt.rx_frame || thresh_hit;
        sticky_set[B_OVR] = evt.rx_overrun;
        sticky_set[B_TXSTOP] = evt.tx_stopped;
        sticky_set[B_RXSTOP] = evt.rx_stopped;
        sticky_set[B_SPACE] = evt.tx_space;
    end

    // write one to clear; a read changes nothing
    assign sticky_clr = (wr_done && wr_addr_q == ADDR_STATUS) ?
                        lane_merge(ZERO16, wr_data_q, wr_be_q) & W1C_MASK :
                        ZERO16;

    // set wins over a clear in the same cycle
    always_comb begin
        next_status = ((interrupt_status & ~sticky_clr) | sticky_set) &
                      W1C_MASK;
        next_status[B_WFRAME] = wake.wake_frame;
        next_status[B_WPKT] = wake.wake_packet;
        next_status[B_LINKUP] = wake.linkup;
        next_status[B_ENERGY] = wake.energy;
    end

    // status storage
    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            interrupt_status <= STATUS_RST;
        end else begin
            interrupt_status <= next_status;
        end
    end

    // ************************************************
    // enable gating and interrupt pin
    // ************************************************
    logic [15:0] gate, pending;
    logic energy_gate;

    // energy: direct, or delayed until host access is ready
    assign energy_gate = (interrupt_enable[B_ENERGY] &&
                          !interrupt_enable[B_DELAY]) ||
                         (interrupt_enable[B_DELAY] &&
                          host_ready);

    // per-source gates, reserved positions never pass
    always_comb begin
        gate = interrupt_enable & ENABLE_MASK;
        gate[B_LINK] = interrupt_enable[B_LINK];
        gate[B_TX] = interrupt_enable[B_TX];
        gate[B_RX] = interrupt_enable[B_RX];
        gate[B_OVR] = interrupt_enable[B_OVR];
        gate[B_TXSTOP] = interrupt_enable[B_TXSTOP];
        gate[B_RXSTOP] = interrupt_enable[B_RXSTOP];
        gate[B_SPACE] = interrupt_enable[B_SPACE];
        gate[B_WFRAME] = interrupt_enable[B_WFRAME];
        gate[B_WPKT] = interrupt_enable[B_WPKT];
        gate[B_LINKUP] = interrupt_enable[B_LINKUP];
        gate[B_ENERGY] = energy_gate;
        gate[B_DELAY] = 1'b0;
    end

    assign pending = interrupt_status & gate;

    // active-low pin from a flop
    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            intr_b <= 1'b1;
        end else begin
            intr_b <= ~(|pending);
        end
    end

    // ************************************************
    // read path
    // ************************************************

    // drive data while a read strobe is seen
    always_ff @(posedge core_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            host_data_out <= ZERO16;
            host_data_oe_b <= 1'b1;
        end else begin
            host_data_oe_b <= !rd_active;
            case (host_sync.addr)
                ADDR_THRESH: host_data_out <= rx_byte_threshold_value;
                ADDR_ENABLE: host_data_out <= interrupt_enable;
                ADDR_STATUS: host_data_out <= interrupt_status &
                                              STATUS_MASK;
                default: host_data_out <= ZERO16;
            endcase
        end
    end

    // ************************************************
    // checks
    // ************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_sync_b);

    thresh_write_a: assert property (
        wr_done && wr_addr_q == ADDR_THRESH && wr_be_q == 2'h0
        |=> rx_byte_threshold_value == $past(wr_data_q))
        else $error("threshold write not stored");

    thresh_trigger_a: assert property (
        rx_byte_thresh_en && above_thresh && !above_thresh_q
        |=> interrupt_status[B_RX])
        else $error("threshold crossing did not set receive status");

    reserved_zero_a: assert property (
        (interrupt_enable & ~ENABLE_MASK) == ZERO16 && !gate[B_DELAY])
        else $error("reserved enable bit set");

    irq_pin_a: assert property (
        ##1 intr_b == !$past(|(interrupt_status & gate)))
        else $error("interrupt pin disagrees with pending");

    link_gate_a: assert property (
        interrupt_status == 16'h8000 && !interrupt_enable[B_LINK]
        |=> intr_b)
        else $error("masked link change reached pin");

    delay_hold_a: assert property (
        interrupt_enable[B_DELAY] && !host_ready |-> !gate[B_ENERGY])
        else $error("delayed energy passed before host ready");

    sticky_hold_a: assert property (
        interrupt_status[B_LINK] && !sticky_clr[B_LINK] && rd_active
        |=> interrupt_status[B_LINK])
        else $error("status bit lost without write one");

    set_wins_a: assert property (
        evt.rx_frame && sticky_clr[B_RX] |=> interrupt_status[B_RX])
        else $error("clear beat a receive event");

    rx_frame_a: assert property (
        evt.rx_frame |=> interrupt_status[B_RX] ##1 !intr_b || !gate[B_RX])
        else $error("receive event not shown at bit 13");

    enable_gate_c: cover property (
        interrupt_enable[B_RX] && evt.rx_frame ##2 !intr_b);
    clear_c: cover property (interrupt_status[B_TX] ##1 sticky_clr[B_TX]);
    delay_c: cover property (interrupt_enable[B_DELAY] && host_ready);

endmodule

// ===== tb/ieb_host_model.sv
// ieb_host_model: host processor on the sram-like register pins.
// assumes a free-running core_clk; drives its pins at falling edges.
`timescale 1ns/1ns
module ieb_host_model
    import ieb_pkg::*;
(
    // clock
    input wire logic core_clk,
    // device read side
    input wire logic [15:0] rdata,
    input wire logic rdata_oe_b,
    // host pins
    output ieb_host_t bus
);
    // ************************************************
    // idle pins, strobes high
    // ************************************************
    initial begin
        bus = '{cs_b: 1'b1, rd_b: 1'b1, wr_b: 1'b1, be_b: 2'b11, addr: 8'h00, wdata: 16'h0000};
    end

    // word write; a one written to status clears that event bit, wake bits follow their inputs
    task automatic write(input logic [7:0] a, input logic [15:0] d);
        @(negedge core_clk);
        bus.addr = a;
        bus.wdata = d;
        bus.be_b = 2'b00;
        bus.cs_b = 1'b0;
        bus.wr_b = 1'b0;
        repeat (6) @(negedge core_clk);
        bus.cs_b = 1'b1;
        bus.wr_b = 1'b1;
        bus.be_b = 2'b11;
        bus.wdata = ~d; // released bus, no stale value
        repeat (6) @(negedge core_clk);
    endtask

    // word read; unknown back unless the device drives the bus
    task automatic read(input logic [7:0] a, output logic [15:0] d);
        @(negedge core_clk);
        bus.addr = a;
        bus.be_b = 2'b00;
        bus.cs_b = 1'b0;
        bus.rd_b = 1'b0;
        repeat (5) @(negedge core_clk);
        d = (rdata_oe_b === 1'b0) ? rdata : 16'hXXXX;
        bus.cs_b = 1'b1;
        bus.rd_b = 1'b1;
        repeat (6) @(negedge core_clk);
    endtask
endmodule

// ===== tb/irq_enable_and_rx_byte_threshold_bench.sv
// irq_enable_and_rx_byte_threshold_bench: self-checking bench for ieb_irq_ctrl.
// assumes the host model for register access; events driven at falling edges.
`timescale 1ns/1ns
module irq_enable_and_rx_byte_threshold_bench;
    import ieb_pkg::*;
    // ************************************************
    // signals
    // ************************************************
    logic core_clk, rst_b, host_data_oe_b, intr_b, rx_byte_thresh_en, host_ready;
    logic [15:0] host_data_out, rx_queue_bytes;
    ieb_host_t hb;
    ieb_event_t evt;
    ieb_wake_t wake;
    int fails, comparisons;
    localparam int EVT_BIT [7] = '{6, 8, 9, 11, 13, 14, 15};
    localparam int WAKE_BIT [4] = '{2, 3, 4, 5};

    ieb_host_model u_host (.core_clk(core_clk), .rdata(host_data_out),
        .rdata_oe_b(host_data_oe_b), .bus(hb));
    ieb_irq_ctrl u_ieb_irq_ctrl (.core_clk(core_clk), .rst_b(rst_b), .host_cs_b(hb.cs_b),
        .host_rd_b(hb.rd_b), .host_wr_b(hb.wr_b), .host_be_b(hb.be_b),
        .host_addr(hb.addr), .host_data_in(hb.wdata), .host_data_out(host_data_out),
        .host_data_oe_b(host_data_oe_b), .evt(evt), .wake(wake),
        .rx_queue_bytes(rx_queue_bytes), .rx_byte_thresh_en(rx_byte_thresh_en),
        .host_ready(host_ready), .intr_b(intr_b));

    // ************************************************
    // clock, watchdog, compare tasks
    // ************************************************
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    initial begin
        #100000;
        fails++;
        finish_test();
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic exp);
        repeat (3) @(negedge core_clk);
        comparisons++;
        if (intr_b !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, intr_b, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        u_host.read(a, d);
        chk_reg(d, exp);
    endtask

    // ************************************************
    // scenarios
    // ************************************************
    task automatic test_regs();
        rd_chk(ADDR_THRESH, 16'h0000);
        rd_chk(ADDR_ENABLE, 16'h0000);
        rd_chk(ADDR_STATUS, 16'h0300);
        u_host.write(ADDR_THRESH, 16'hA5C3);
        rd_chk(ADDR_THRESH, 16'hA5C3);
        u_host.write(ADDR_ENABLE, 16'hFFFF);
        rd_chk(ADDR_ENABLE, 16'hEB7D);
        u_host.write(ADDR_ENABLE, 16'h1482);
        rd_chk(ADDR_ENABLE, 16'h0000);
        chk_pin(1'b1);
        rd_chk(8'h80, 16'h0000);
        $display("test_regs done");
    endtask

    task automatic test_events();
        u_host.write(ADDR_STATUS, 16'hFFFF);
        for (int i = 0; i < 7; i++) begin
            @(negedge core_clk);
            evt[i] = 1'b1;
            @(negedge core_clk);
            evt = '0;
            chk_pin(1'b1);
            u_host.write(ADDR_ENABLE, 16'h0001 << EVT_BIT[i]);
            chk_pin(1'b0);
            rd_chk(ADDR_STATUS, 16'h0001 << EVT_BIT[i]);
            rd_chk(ADDR_STATUS, 16'h0001 << EVT_BIT[i]);
            u_host.write(ADDR_STATUS, 16'h0001 << EVT_BIT[i]);
            chk_pin(1'b1);
            u_host.write(ADDR_ENABLE, 16'h0000);
        end
        $display("test_events done");
    endtask

    task automatic test_wake();
        for (int j = 0; j < 4; j++) begin
            @(negedge core_clk);
            wake[j] = 1'b1;
            chk_pin(1'b1);
            u_host.write(ADDR_ENABLE, 16'h0001 << WAKE_BIT[j]);
            chk_pin(1'b0);
            // energy level stays up from the first pass for the delay check
            rd_chk(ADDR_STATUS, (16'h0001 << WAKE_BIT[j]) | 16'h0004);
            u_host.write(ADDR_ENABLE, 16'h0000);
            if (j > 0) begin
                wake[j] = 1'b0;
            end
        end
        u_host.write(ADDR_ENABLE, 16'h0001);
        chk_pin(1'b1);
        host_ready = 1'b1;
        chk_pin(1'b0);
        wake = '0;
        chk_pin(1'b1);
        u_host.write(ADDR_ENABLE, 16'h0000);
        $display("test_wake done");
    endtask

    task automatic test_thresh();
        u_host.write(ADDR_THRESH, 16'h0064);
        rx_queue_bytes = 16'h0064;
        rx_byte_thresh_en = 1'b1;
        rd_chk(ADDR_STATUS, 16'h0000);
        rx_queue_bytes = 16'h0065;
        rd_chk(ADDR_STATUS, 16'h2000);
        u_host.write(ADDR_ENABLE, 16'h2000);
        chk_pin(1'b0);
        u_host.write(ADDR_STATUS, 16'h2000);
        rx_queue_bytes = 16'h0000;
        rx_byte_thresh_en = 1'b0;
        chk_pin(1'b1);
        rx_queue_bytes = 16'h0065;
        rd_chk(ADDR_STATUS, 16'h0000);
        $display("test_thresh done");
    endtask

    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        rst_b = 1'b0;
        evt = '0;
        wake = '0;
        rx_queue_bytes = 16'h0000;
        rx_byte_thresh_en = 1'b0;
        host_ready = 1'b0;
        fails = 0;
        comparisons = 0;
        repeat (16) @(negedge core_clk);
        rst_b = 1'b1;
        repeat (6) @(negedge core_clk);
        chk_pin(1'b1);
        test_regs();
        test_events();
        test_wake();
        test_thresh();
        finish_test();
    end
endmodule
